// ==== design/sfr_i2c_slave.sv ====
// Two-wire serial slave in front of a 2048-byte nonvolatile array
//
// How it works
// - Array of 2048 byte locations, each addressed on its own.
// - Each received data byte is written at once; no busy time.
// - Data line is only pulled low or released, never driven high.
// - Bits are sampled on clock rise, outgoing bits change on clock fall.
// - Write-protect high blocks every write to the array.
// - Write-protect low lets all writes through; pin pulled low outside.
// - Works with bus clocks up to 1 MHz, also 100 and 400 kHz.
// - Select byte: type in bits 7-4, block in 3-1, read in bit 0.
// - 11-bit address steps after each data byte, wraps 7FF to 000.
// - Reads continue on master acknowledge, end on its missing acknowledge.
// - Stop aborts an operation; start aborts and readies a new command.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_map.svh"

module sfr_i2c_slave #(
	parameter logic [3:0] DEV_TYPE = `SFR_DEV_TYPE_DEF, // Arbitrary value
	parameter int DEPTH = `SFR_MEM_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic wp_in,
	output var logic sda_out,
	output var logic sda_oen
);

	// ****************************************************************
	// Input settling
	// ****************************************************************

	// Accept a new level only once the last two stages agree
	function automatic logic settle(input logic s2, input logic s3, input logic cur);
		return (s2 == s3) ? s3 : cur;
	endfunction

	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] wp_sync_reg;
	logic scl_reg;
	logic sda_reg;
	logic wp_reg;
	logic scl_next;
	logic sda_next;
	logic wp_next;

	// Three-stage chains; stage 0 feeds only stage 1
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_sync_reg <= `SFR_BUS_IDLE_SYNC;
			sda_sync_reg <= `SFR_BUS_IDLE_SYNC;
			wp_sync_reg <= `SFR_WP_IDLE_SYNC;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			wp_sync_reg <= {wp_sync_reg[1:0], wp_in};
		end
	end

	// Settled levels; 50 clocks per 1 MHz bit leaves margin for latency
	assign scl_next = settle(scl_sync_reg[1], scl_sync_reg[2], scl_reg);
	assign sda_next = settle(sda_sync_reg[1], sda_sync_reg[2], sda_reg);
	assign wp_next = settle(wp_sync_reg[1], wp_sync_reg[2], wp_reg);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			wp_reg <= 1'b0;
		end else begin
			scl_reg <= scl_next;
			sda_reg <= sda_next;
			wp_reg <= wp_next;
		end
	end

	// ****************************************************************
	// Bus events
	// ****************************************************************
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	// Data edges while the clock stays high mark start and stop
	assign scl_rise = scl_next & ~scl_reg;
	assign scl_fall = ~scl_next & scl_reg;
	assign start_cond = scl_reg & scl_next & sda_reg & ~sda_next;
	assign stop_cond = scl_reg & scl_next & ~sda_reg & sda_next;

	// ****************************************************************
	// Byte engine
	// ****************************************************************
	sfr_pkg::sfr_state_t state_reg;
	sfr_pkg::sfr_kind_t kind_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg;
	logic rw_reg;
	logic mack_reg;
	logic [`SFR_ADDR_W-1:0] addr_reg;
	logic rx_byte_done;
	logic tx_byte_done;
	logic dev_ok;
	logic wr_en;
	logic data_step;
	sfr_mem_if mem_port ();

	assign rx_byte_done = (state_reg == sfr_pkg::SFR_RX) && scl_fall
		&& (cnt_reg == `SFR_BITS_PER_BYTE);
	assign tx_byte_done = (state_reg == sfr_pkg::SFR_TX) && scl_fall
		&& (cnt_reg == `SFR_BITS_PER_BYTE);
	assign dev_ok = (shift_reg[`SFR_TYPE_MSB:`SFR_TYPE_LSB] == DEV_TYPE);
	// Commit only when unprotected; protected bytes are still acknowledged
	assign wr_en = rx_byte_done && (kind_reg == sfr_pkg::SFR_KIND_DATA) && !wp_reg;
	assign data_step = (rx_byte_done && (kind_reg == sfr_pkg::SFR_KIND_DATA))
		|| tx_byte_done;

	// Phase sequencing; start and stop override everything
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= sfr_pkg::SFR_IDLE;
			kind_reg <= sfr_pkg::SFR_KIND_DEV;
			cnt_reg <= `SFR_CNT_RST;
			shift_reg <= `SFR_BYTE_RST;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
		end else if (start_cond) begin
			state_reg <= sfr_pkg::SFR_RX;
			kind_reg <= sfr_pkg::SFR_KIND_DEV;
			cnt_reg <= `SFR_CNT_RST;
		end else if (stop_cond) begin
			state_reg <= sfr_pkg::SFR_IDLE;
		end else begin
			case (state_reg)
				sfr_pkg::SFR_RX: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_reg};
						cnt_reg <= cnt_reg + `SFR_CNT_ONE;
					end else if (rx_byte_done) begin
						if (kind_reg == sfr_pkg::SFR_KIND_DEV && !dev_ok) begin
							state_reg <= sfr_pkg::SFR_IDLE;
						end else begin
							state_reg <= sfr_pkg::SFR_ACK;
							if (kind_reg == sfr_pkg::SFR_KIND_DEV) begin
								rw_reg <= shift_reg[`SFR_RW_BIT];
							end
						end
					end
				end
				sfr_pkg::SFR_ACK: begin
					if (scl_fall) begin
						cnt_reg <= `SFR_CNT_RST;
						if (kind_reg == sfr_pkg::SFR_KIND_DEV && rw_reg) begin
							state_reg <= sfr_pkg::SFR_TX;
							shift_reg <= mem_port.rdata;
						end else begin
							state_reg <= sfr_pkg::SFR_RX;
							kind_reg <= (kind_reg == sfr_pkg::SFR_KIND_DEV) ?
								sfr_pkg::SFR_KIND_WORD : sfr_pkg::SFR_KIND_DATA;
						end
					end
				end
				sfr_pkg::SFR_TX: begin
					if (scl_rise) begin
						cnt_reg <= cnt_reg + `SFR_CNT_ONE;
					end else if (tx_byte_done) begin
						state_reg <= sfr_pkg::SFR_TX_ACK;
					end else if (scl_fall) begin
						shift_reg <= {shift_reg[6:0], 1'b0};
					end
				end
				sfr_pkg::SFR_TX_ACK: begin
					if (scl_rise) begin
						mack_reg <= ~sda_reg;
					end else if (scl_fall) begin
						if (mack_reg) begin
							state_reg <= sfr_pkg::SFR_TX;
							shift_reg <= mem_port.rdata;
							cnt_reg <= `SFR_CNT_RST;
						end else begin
							state_reg <= sfr_pkg::SFR_IDLE;
						end
					end
				end
				default: begin
					state_reg <= sfr_pkg::SFR_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Address latch
	// ****************************************************************

	// Block from the select byte, low byte from the word address
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_reg <= `SFR_ADDR_RST;
		end else if (rx_byte_done && kind_reg == sfr_pkg::SFR_KIND_DEV && dev_ok) begin
			addr_reg[`SFR_ADDR_W-1:8] <= shift_reg[`SFR_PAGE_MSB:`SFR_PAGE_LSB];
		end else if (rx_byte_done && kind_reg == sfr_pkg::SFR_KIND_WORD) begin
			addr_reg[7:0] <= shift_reg;
		end else if (data_step) begin
			addr_reg <= addr_reg + `SFR_ADDR_ONE;
		end
	end

	// ****************************************************************
	// Data line drive
	// ****************************************************************

	// Enable low pulls the line; the output level itself never leaves 0
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sda_out <= 1'b0;
			sda_oen <= 1'b1;
		end else begin
			sda_out <= 1'b0;
			if (start_cond || stop_cond) begin
				sda_oen <= 1'b1;
			end else if (rx_byte_done) begin
				sda_oen <= (kind_reg == sfr_pkg::SFR_KIND_DEV) && !dev_ok;
			end else if (scl_fall) begin
				case (state_reg)
					sfr_pkg::SFR_ACK: begin
						sda_oen <= (kind_reg == sfr_pkg::SFR_KIND_DEV && rw_reg) ?
							mem_port.rdata[7] : 1'b1;
					end
					sfr_pkg::SFR_TX: begin
						sda_oen <= (cnt_reg == `SFR_BITS_PER_BYTE) ? 1'b1 : shift_reg[6];
					end
					sfr_pkg::SFR_TX_ACK: begin
						sda_oen <= mack_reg ? mem_port.rdata[7] : 1'b1;
					end
					default: begin
						sda_oen <= 1'b1;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Array
	// ****************************************************************
	assign mem_port.wr_en = wr_en;
	assign mem_port.addr = addr_reg;
	assign mem_port.wdata = shift_reg;

	sfr_mem #(
		.DEPTH(DEPTH)
	) u_mem (
		.clk(clk),
		.mem(mem_port)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_start;
		start_cond;
	endsequence

	sequence s_data_byte;
		rx_byte_done && kind_reg == sfr_pkg::SFR_KIND_DATA;
	endsequence

	chk_line_never_high: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	chk_wp_blocks_write: assert property (s_data_byte ##0 wp_reg |-> !mem_port.wr_en)
		else $error("write while protected");
	chk_data_byte_acked: assert property (s_data_byte |=>
		state_reg == sfr_pkg::SFR_ACK && !sda_oen ##0 $past(addr_reg) + `SFR_ADDR_ONE == addr_reg)
		else $error("data byte not acknowledged or address not stepped");
	// Looks into the array itself, so a lost commit in the store is caught too
	chk_open_write: assert property (s_data_byte ##0 !wp_reg |=>
		u_mem.array_reg[$past(addr_reg)] == $past(shift_reg))
		else $error("unprotected byte not committed");
	chk_addr_wrap: assert property (data_step && addr_reg == `SFR_ADDR_LAST |=>
		addr_reg == `SFR_ADDR_RST)
		else $error("address did not wrap");
	chk_start_rearm: assert property (s_start |=> state_reg == sfr_pkg::SFR_RX
		&& kind_reg == sfr_pkg::SFR_KIND_DEV && cnt_reg == `SFR_CNT_RST ##1 sda_oen)
		else $error("start did not rearm");
	chk_stop_abort: assert property (stop_cond |=> state_reg == sfr_pkg::SFR_IDLE
		&& sda_oen)
		else $error("stop did not abort");
	chk_drive_on_fall: assert property ($fell(sda_oen) |-> $past(scl_fall))
		else $error("drive began off a falling edge");
	chk_read_nack_end: assert property (state_reg == sfr_pkg::SFR_TX_ACK && scl_fall
		&& !mack_reg && !start_cond && !stop_cond |=> state_reg == sfr_pkg::SFR_IDLE
		&& sda_oen [*2])
		else $error("read kept going after missing acknowledge");

endmodule

`default_nettype wire

// ==== common/sfr_map.svh ====
// Constants for the serial byte-memory slave: layout, field positions, reset values
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define SFR_ADDR_W 11
`define SFR_MEM_DEPTH 2048
`define SFR_ADDR_LAST 11'h7FF
`define SFR_ADDR_ONE 11'h001
`define SFR_ADDR_RST 11'h000

// ****************************************************************
// Select byte fields
// ****************************************************************
`define SFR_TYPE_MSB 7
`define SFR_TYPE_LSB 4
`define SFR_PAGE_MSB 3
`define SFR_PAGE_LSB 1
`define SFR_RW_BIT 0
`define SFR_DEV_TYPE_DEF 4'h5

// ****************************************************************
// Bit counting and reset values
// ****************************************************************
`define SFR_BITS_PER_BYTE 4'h8
`define SFR_CNT_RST 4'h0
`define SFR_CNT_ONE 4'h1
`define SFR_BYTE_RST 8'h00
`define SFR_BUS_IDLE_SYNC 3'h7
`define SFR_WP_IDLE_SYNC 3'h0

`endif

// ==== common/sfr_pkg.sv ====
// Types shared by the serial byte-memory slave
`default_nettype none

package sfr_pkg;

	// Bus phase of the slave
	typedef enum logic [2:0] {
		SFR_IDLE,
		SFR_RX,
		SFR_ACK,
		SFR_TX,
		SFR_TX_ACK
	} sfr_state_t;

	// Meaning of the byte being received
	typedef enum logic [1:0] {
		SFR_KIND_DEV,
		SFR_KIND_WORD,
		SFR_KIND_DATA
	} sfr_kind_t;

endpackage

`default_nettype wire

// ==== common/sfr_mem_if.sv ====
// Port between the bus engine and the byte array
`timescale 1ns/100ps
`default_nettype none
`include "sfr_map.svh"

interface sfr_mem_if;
	logic wr_en;
	logic [`SFR_ADDR_W-1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	// Engine side
	modport ctrl (
		output wr_en,
		output addr,
		output wdata,
		input rdata
	);

	// Array side
	modport store (
		input wr_en,
		input addr,
		input wdata,
		output rdata
	);
endinterface

`default_nettype wire

// ==== design/sfr_mem.sv ====
// Byte array of the serial memory slave
`timescale 1ns/100ps
`default_nettype none
`include "sfr_map.svh"

module sfr_mem #(
	parameter int DEPTH = `SFR_MEM_DEPTH
) (
	input wire logic clk,
	sfr_mem_if.store mem
);

	// Contents carry no reset: a nonvolatile array keeps what it holds
	logic [7:0] array_reg [DEPTH];

	// Byte commit, on the same clock edge that closes the byte
	always_ff @(posedge clk) begin
		if (mem.wr_en) begin
			array_reg[mem.addr] <= mem.wdata;
		end
	end

	// Read is combinational so the next byte is ready at the falling edge
	assign mem.rdata = array_reg[mem.addr];

endmodule

`default_nettype wire

// ==== tb/sfr_i2c_master_model.sv ====
// Two-wire bus master model that drives the serial clock for the slave bench
`timescale 1ns/100ps
`default_nettype none

module sfr_i2c_master_model #(
	parameter int HALF = 25 // Clocks per bus clock phase, 1 us period
) (
	input wire logic clk,
	input wire logic sda_w,
	output var logic scl,
	output var logic sda_m
);
	// ****************************************************************
	// Bus conditions and bit cycles
	// ****************************************************************

	// Bus idles released; pull-up gives high
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves mid low phase, so it never changes while the clock is high
	task automatic cbit(input logic b, output logic s);
		sda_m <= b;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF / 2);
		s = sda_w;
		tick(HALF - HALF / 2);
		scl <= 1'b0;
		tick(HALF - HALF / 2);
	endtask

	// Works from idle and as a repeated start
	task automatic start();
		sda_m <= 1'b1;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF / 2);
		sda_m <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b0;
		tick(HALF / 2);
	endtask

	task automatic stop();
		sda_m <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF / 2);
		sda_m <= 1'b1;
		tick(HALF);
	endtask

	// Byte out MSB first, line released for the slave's ack
	task automatic wb(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			cbit(d[i], s);
		end
		cbit(1'b1, s);
		ack = ~s;
	endtask

	// Byte in; no ack on the last byte lets the slave let go
	task automatic rb(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			cbit(1'b1, s);
			d[i] = s;
		end
		cbit(~mack, s);
	endtask
endmodule

`default_nettype wire

// ==== tb/sfr_i2c_slave_tb_top.sv ====
// Self-checking bench for the two-wire serial byte-memory slave
`timescale 1ns/100ps
`default_nettype none

module sfr_i2c_slave_tb_top;
	localparam logic [3:0] TYPE = 4'h6; // Arbitrary device-type value
	logic clk, rstn, wp_in, sda_out, sda_oen, scl, sda_m, sda_w;
	logic [7:0] d0, d1;
	logic a;
	int error_cnt = 0;
	int compares = 0;

	// Wired-AND data line with pull-up
	assign sda_w = sda_m & (sda_oen | sda_out);

	sfr_i2c_slave #(.DEV_TYPE(TYPE)) dut (.clk(clk), .rstn(rstn), .scl_in(scl),
		.sda_in(sda_w), .wp_in(wp_in), .sda_out(sda_out), .sda_oen(sda_oen));
	sfr_i2c_master_model mst (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d, error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Slave may only pull low, never drive high
	always @(negedge clk) begin
		if (rstn === 1'b1 && sda_oen === 1'b0) begin
			chk("sda_out", {7'h00, sda_out}, 8'h00);
		end
	end

	// ****************************************************************
	// Bus helpers
	// ****************************************************************
	task automatic sel(input logic [2:0] blk, input logic rd);
		mst.wb({TYPE, blk, rd}, a);
		chk("select ack", {7'h00, a}, 8'h01);
	endtask

	task automatic send(input logic [7:0] d);
		mst.wb(d, a);
		chk("byte ack", {7'h00, a}, 8'h01);
	endtask

	// Load the 11-bit pointer with a write select and a word byte
	task automatic ptr(input logic [10:0] ad);
		mst.start();
		sel(ad[10:8], 1'b0);
		send(ad[7:0]);
	endtask

	task automatic wr2(input logic [10:0] ad, input logic [7:0] x0, input logic [7:0] x1);
		ptr(ad);
		send(x0);
		send(x1);
		mst.stop();
	endtask

	task automatic rd2(input logic [10:0] ad);
		ptr(ad);
		mst.start();
		sel(ad[10:8], 1'b1);
		mst.rb(1'b1, d0);
		mst.rb(1'b0, d1);
		mst.stop();
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_basic();
		wr2(11'h310, 8'hA5, 8'h3C);
		rd2(11'h310);
		chk("first byte", d0, 8'hA5);
		chk("second byte", d1, 8'h3C);
		$display("test basic done");
	endtask

	task automatic t_wrap();
		wr2(11'h7FF, 8'h11, 8'h22);
		rd2(11'h7FF);
		chk("last location", d0, 8'h11);
		chk("wrapped location", d1, 8'h22);
		$display("test wrap done");
	endtask

	// Protected write is acked and steps the pointer, then read the next byte
	task automatic t_protect();
		wp_in <= 1'b1;
		ptr(11'h310);
		mst.wb(8'hFF, a);
		chk("protected ack", {7'h00, a}, 8'h01);
		mst.start();
		sel(3'h3, 1'b1);
		mst.rb(1'b0, d0);
		mst.stop();
		chk("pointer advanced", d0, 8'h3C);
		wp_in <= 1'b0;
		rd2(11'h310);
		chk("protected byte", d0, 8'hA5);
		$display("test protect done");
	endtask

	task automatic t_badtype();
		mst.start();
		mst.wb({TYPE ^ 4'h1, 3'h0, 1'b0}, a);
		chk("foreign select ack", {7'h00, a}, 8'h00);
		mst.stop();
		$display("test badtype done");
	endtask

	// Partial bytes cut by stop and by start must not reach the array
	task automatic t_abort();
		logic s;
		wr2(11'h020, 8'h5A, 8'hC3);
		ptr(11'h020);
		repeat (4) mst.cbit(1'b1, s);
		mst.stop();
		rd2(11'h020);
		chk("after stop abort", d0, 8'h5A);
		ptr(11'h020);
		repeat (3) mst.cbit(1'b0, s);
		mst.start();
		sel(3'h0, 1'b1);
		mst.rb(1'b0, d0);
		mst.stop();
		chk("after start abort", d0, 8'h5A);
		$display("test abort done");
	endtask

	// ****************************************************************
	// Clock, reset, sequence and watchdog
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		rstn = 1'b0;
		wp_in = 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		chk("idle enable", {7'h00, sda_oen}, 8'h01);
		t_basic();
		t_wrap();
		t_protect();
		t_badtype();
		t_abort();
		end_sim();
	end

	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		$display("unexpected run length: expected done, seen running");
		end_sim();
	end
endmodule

`default_nettype wire
